// file: rtl/dma_channels.sv
// eight dma channels: address, count and collision status registers
// assumes: ahb-lite single master, word accesses, one system clock
// Summary of operation
// R1 - each channel holds a 16-bit writable primary ram start address
// R2 - each channel holds a 16-bit writable secondary ram start address
// R3 - each channel holds a 16-bit writable peripheral address
// R4 - software avoids writing peripheral address or count while channel on
// R5 - count register holds 10 writable bits, upper six read zero
// R6 - a block moves programmed count plus one items
// R7 - status bits 15..8 are peripheral write collision flags, clearable
// R8 - status bits 7..0 are ram write collision flags, clearable
// R9 - a flag reads one after a collision, zero otherwise
// R10 - addresses, count and collision flags reset to zero
// R11 - ping-pong alternates primary and secondary start each block
// R12 - continuous mode reloads the start address after each block
// R13 - mode field: 00 post-increment, 01 no increment, 10 peripheral; the sequencer treats 10 like 01, no increment
// R14 - interrupt at block end, or at half block when configured
// R15 - internal counter restarts each block, done at count plus one
`timescale 1ns/1ns
`include "dma_consts.svh"
module dma_channels
   import dma_pkg::*;
#(
   parameter int NCH = 8
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  xfer_step,
   input  wire logic [7:0]  periph_collision,
   input  wire logic [7:0]  ram_collision,
   output logic      [15:0] ram_addr_flat [8],
   output logic      [15:0] periph_addr_flat [8],
   output logic      [7:0]  chan_busy,
   output logic             irq
);
   logic [15:0] pri_start_reg [NCH];
   logic [15:0] sec_start_reg [NCH];
   logic [15:0] pad_reg       [NCH];
   logic [9:0]  blk_len_reg   [NCH];
   logic [15:0] ctrl_reg      [NCH];
   logic [15:0] col_reg, col_next;
   logic [7:0]  ist_reg, ist_next;
   logic [7:0]  imask_reg;
   logic [7:0]  done_v, hev_v, busy_v;
   logic [15:0] addr_v [NCH];
   logic        wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic [31:0] rdata_next;
   logic        irq_next;
   logic        rd_take;
   logic [2:0]  rch;
   logic [11:0] roff;
   logic [11:0] woff;

   // one sequencer per channel
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gch
         dma_chan_if cif ();
         assign cif.pri_start = pri_start_reg[g];
         assign cif.sec_start = sec_start_reg[g];
         assign cif.blk_len   = blk_len_reg[g];
         assign cif.on     = ctrl_reg[g][`CTRL_ON_BIT];
         assign cif.half   = ctrl_reg[g][`CTRL_HALF_BIT];
         assign cif.addr_mode = ctrl_reg[g][`CTRL_ADDR_MODE_LO +: 2];
         assign cif.opmode = ctrl_reg[g][`CTRL_MODE_LO +: 2];
         assign cif.step   = xfer_step[g];
         assign done_v[g]  = cif.done;
         assign hev_v[g]   = cif.half_evt;
         assign busy_v[g]  = cif.busy;
         assign addr_v[g]  = cif.ram_addr;
         dma_chan_seq u_seq (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ch      (cif.chan)
         );
      end
   endgenerate

   // address phase capture for writes, reads answered next cycle
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign rch  = haddr[7:5];
   assign roff = haddr & 12'h01f;
   assign woff = wr_addr_reg & 12'h01f;

   // read mux over the address phase
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (haddr >= `OFF_STAT) begin
         if (haddr == `OFF_STAT)
            rdata_next = {16'h0000, col_reg};                    // R9
         else if (haddr == `OFF_IRQ_STAT)
            rdata_next = {24'h000000, ist_reg};
         else if (haddr == `OFF_IRQ_MASK)
            rdata_next = {24'h000000, imask_reg};
      end else if (roff == `OFF_PRI_START)
         rdata_next = {16'h0000, pri_start_reg[rch]};             // R1
      else if (roff == `OFF_SEC_START)
         rdata_next = {16'h0000, sec_start_reg[rch]};             // R2
      else if (roff == `OFF_PAD)
         rdata_next = {16'h0000, pad_reg[rch]};                   // R3
      else if (roff == `OFF_LENGTH)
         rdata_next = {22'h0, blk_len_reg[rch]};                  // R5
      else if (roff == `OFF_CTRL)
         rdata_next = {16'h0000, ctrl_reg[rch] & 16'h9833};
      else
         rdata_next = 32'h0000_0000;
   end

   // collision and interrupt flags: set wins over write-one-clear
   always_comb begin
      col_next = col_reg;
      ist_next = ist_reg;
      if (wr_pend_reg && wr_addr_reg == `OFF_STAT)
         col_next = col_reg & ~hwdata[15:0];                      // R7 R8
      if (wr_pend_reg && wr_addr_reg == `OFF_IRQ_STAT)
         ist_next = ist_reg & ~hwdata[7:0];
      col_next = col_next | {periph_collision, ram_collision};    // R7 R8 R9
      ist_next = ist_next | done_v | hev_v;                       // R14
      irq_next = |(ist_next & imask_reg);
   end

   // bus state, flags and outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         col_reg     <= `RESET_16;                                // R10
         ist_reg     <= 8'h00;
         irq         <= 1'b0;
      end else begin
         wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
         wr_addr_reg <= haddr;
         if (rd_take)
            hrdata <= rdata_next;
         col_reg <= col_next;
         ist_reg <= ist_next;
         irq     <= irq_next;
      end
   end

   // software-written per-channel registers
   generate
      for (g = 0; g < NCH; g++) begin : gregs
         logic hit;
         assign hit = wr_pend_reg && wr_addr_reg < `OFF_STAT
                      && wr_addr_reg[7:5] == 3'(g);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pri_start_reg[g] <= `RESET_16;                     // R10
               sec_start_reg[g] <= `RESET_16;
               pad_reg[g]       <= `RESET_16;
               blk_len_reg[g]   <= 10'h000;
               ctrl_reg[g]      <= `RESET_16;
            end else if (hit) begin
               if (woff == `OFF_PRI_START)
                  pri_start_reg[g] <= hwdata[15:0];               // R1
               else if (woff == `OFF_SEC_START)
                  sec_start_reg[g] <= hwdata[15:0];               // R2
               else if (woff == `OFF_PAD)
                  pad_reg[g] <= hwdata[15:0];                     // R3
               else if (woff == `OFF_LENGTH)
                  blk_len_reg[g] <= hwdata[9:0];                  // R5
               else if (woff == `OFF_CTRL)
                  ctrl_reg[g] <= hwdata[15:0] & 16'h9833;
            end
         end
         // registered outputs toward ram and peripherals
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ram_addr_flat[g]    <= `RESET_16;
               periph_addr_flat[g] <= `RESET_16;
               chan_busy[g]        <= 1'b0;
            end else begin
               ram_addr_flat[g]    <= addr_v[g];
               periph_addr_flat[g] <= pad_reg[g];
               chan_busy[g]        <= busy_v[g];
            end
         end
      end
   endgenerate

   // mask register, written as a whole byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         imask_reg <= 8'h00;
      else if (wr_pend_reg && wr_addr_reg == `OFF_IRQ_MASK)
         imask_reg <= hwdata[7:0];
   end
endmodule : dma_channels

// file: rtl/dma_consts.svh
// register offsets, field positions and reset values for the dma block
// assumes: included by the design modules, the property module and the bench
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH
`define CH_STRIDE       12'h020
`define OFF_PRI_START   12'h000
`define OFF_SEC_START   12'h004
`define OFF_PAD         12'h008
`define OFF_LENGTH      12'h00c
`define OFF_CTRL        12'h010
`define OFF_STAT        12'h100
`define OFF_IRQ_STAT    12'h104
`define OFF_IRQ_MASK    12'h108
`define LEN_W           10
`define CTRL_ON_BIT     15
`define CTRL_HALF_BIT   12
`define CTRL_ADDR_MODE_LO 4
`define CTRL_MODE_LO    0
`define RESET_16        16'h0000
`endif

// file: rtl/dma_pkg.sv
// types shared by the dma channel modules
// assumes: nothing beyond the constants header
package dma_pkg;
   typedef enum logic [1:0] {
      inc_after,
      inc_none,
      periph_indirect,
      mode_reserved
   } addr_mode_t;
   typedef enum logic [1:0] {
      op_continuous,
      op_one_shot,
      op_cont_pingpong,
      op_shot_pingpong
   } opmode_t;
endpackage : dma_pkg

// file: rtl/dma_chan_if.sv
// bundle between the register file and one channel sequencer
// assumes: same clock on both ends
`timescale 1ns/1ns
interface dma_chan_if;
   logic [15:0] pri_start;
   logic [15:0] sec_start;
   logic [9:0]  blk_len;
   logic        on;
   logic        half;
   logic [1:0]  addr_mode;
   logic [1:0]  opmode;
   logic        step;
   logic [15:0] ram_addr;
   logic        done;
   logic        half_evt;
   logic        busy;
   modport regs (output pri_start, sec_start, blk_len, on, half,
                 addr_mode, opmode, step,
                 input ram_addr, done, half_evt, busy);
   modport chan (input pri_start, sec_start, blk_len, on, half,
                 addr_mode, opmode, step,
                 output ram_addr, done, half_evt, busy);
endinterface : dma_chan_if

// file: rtl/dma_chan_seq.sv
// one channel's block sequencer: address, counter, ping-pong select
// assumes: step pulses come from the same clock, one per transfer
`timescale 1ns/1ns
`include "dma_consts.svh"
module dma_chan_seq
   import dma_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   dma_chan_if.chan ch
);
   logic [9:0]  xfer_reg, xfer_next;
   logic [15:0] addr_reg, addr_next;
   logic        pp_reg, pp_next;
   logic        busy_reg, busy_next;
   logic        done_reg, done_next;
   logic        hev_reg, hev_next;
   logic        fin_reg, fin_next;
   logic        pp_mode;

   assign pp_mode = ch.opmode[1];

   // next state of counter, address and buffer select
   always_comb begin
      xfer_next = xfer_reg;
      addr_next = addr_reg;
      pp_next   = pp_reg;
      busy_next = busy_reg;
      fin_next  = fin_reg;
      done_next = 1'b0;
      hev_next  = 1'b0;
      if (!ch.on) begin
         busy_next = 1'b0;
         fin_next  = 1'b0;
         xfer_next = '0;
         pp_next   = 1'b0;
      end else if (!busy_reg && !fin_reg) begin
         busy_next = 1'b1;
         xfer_next = '0;                                          // R15
         addr_next = pp_reg ? ch.sec_start : ch.pri_start;        // R1
      end else if (busy_reg && ch.step) begin
         if (ch.addr_mode == inc_after)
            addr_next = addr_reg + 16'h0001;                      // R13
         if (ch.half && xfer_reg == (ch.blk_len >> 1))
            hev_next = 1'b1;                                      // R14
         if (xfer_reg == ch.blk_len) begin                        // R6
            done_next = ~ch.half;                                 // R14
            xfer_next = '0;                                       // R15
            if (pp_mode)
               pp_next = ~pp_reg;                                 // R11
            addr_next = (pp_mode && !pp_reg) ? ch.sec_start
                                             : ch.pri_start;      // R12 R2
            // one-shot parks until software turns the channel off
            if (ch.opmode[0]) begin
               busy_next = 1'b0;
               fin_next  = 1'b1;
            end
         end else begin
            xfer_next = xfer_reg + 10'h001;                       // R15
         end
      end
   end

   // register the sequencer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xfer_reg <= '0;
         addr_reg <= `RESET_16;
         pp_reg   <= 1'b0;
         busy_reg <= 1'b0;
         fin_reg  <= 1'b0;
         done_reg <= 1'b0;
         hev_reg  <= 1'b0;
      end else begin
         xfer_reg <= xfer_next;
         addr_reg <= addr_next;
         pp_reg   <= pp_next;
         busy_reg <= busy_next;
         fin_reg  <= fin_next;
         done_reg <= done_next;
         hev_reg  <= hev_next;
      end
   end

   assign ch.ram_addr = addr_reg;
   assign ch.done     = done_reg;
   assign ch.half_evt = hev_reg;
   assign ch.busy     = busy_reg;
endmodule : dma_chan_seq

// file: sim/dma_far_side.sv
// peripheral and dma ram side: item steps and collision pulses
// assumes: same hclk as the register block, pulses one cycle wide
`timescale 1ns/1ns
module dma_far_side (
   input  wire logic       hclk,
   output logic      [7:0] xfer_step,
   output logic      [7:0] periph_collision,
   output logic      [7:0] ram_collision
);
   // quiet lines from time zero
   initial begin
      xfer_step = 8'h00;
      periph_collision = 8'h00;
      ram_collision = 8'h00;
   end
   // one pulse per moved item, idle cycle between items
   task step(input int ch, input int n);
      repeat (n) begin
         @(posedge hclk);
         xfer_step[ch] <= 1'b1;
         @(posedge hclk);
         xfer_step[ch] <= 1'b0;
      end
   endtask : step
   // collision seen on the given channels for one cycle
   task clash(input logic [7:0] p, input logic [7:0] r);
      @(posedge hclk);
      periph_collision <= p;
      ram_collision <= r;
      @(posedge hclk);
      periph_collision <= 8'h00;
      ram_collision <= 8'h00;
   endtask : clash
endmodule : dma_far_side

// file: sim/dma_channels_properties.sv
// port assertions for the dma channel register block
// assumes: bound to dma_channels, one clock, word accesses
`timescale 1ns/1ns
`include "dma_consts.svh"
module dma_channels_props
   import dma_pkg::*;
#(
   parameter int NCH = 8
)
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [15:0] periph_addr_flat [8],
   input wire logic [7:0]  chan_busy,
   input wire logic        irq
);
   logic        rq;
   logic        wq;
   logic [11:0] qa;
   logic [15:0] pri_e;
   logic [15:0] sec_e;
   logic [15:0] pad_e;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // data phase tracking and last written channel 0 values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rq <= 1'b0;
         wq <= 1'b0;
         qa <= 12'h000;
         pri_e <= 16'h0000;
         sec_e <= 16'h0000;
         pad_e <= 16'h0000;
      end else begin
         rq <= hsel && hready && htrans[1] && !hwrite;
         wq <= hsel && hready && htrans[1] && hwrite;
         qa <= haddr;
         if (wq && qa == `OFF_PRI_START) pri_e <= hwdata[15:0];
         if (wq && qa == `OFF_SEC_START) sec_e <= hwdata[15:0];
         if (wq && qa == `OFF_PAD) pad_e <= hwdata[15:0];
      end
   end
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("ready low");
   a_len_upper: assert property (
      rq && qa < `OFF_STAT && (qa & 12'h01f) == `OFF_LENGTH
         |-> hrdata[31:10] == 22'h000000)
      else $error("count upper bits set");
   a_stat_upper: assert property (
      rq && qa == `OFF_STAT |-> hrdata[31:16] == 16'h0000)
      else $error("status upper bits set");
   a_pri_back: assert property (
      rq && qa == `OFF_PRI_START |-> hrdata == {16'h0000, pri_e})
      else $error("primary start readback wrong");
   a_sec_back: assert property (
      rq && qa == `OFF_SEC_START |-> hrdata == {16'h0000, sec_e})
      else $error("secondary start readback wrong");
   a_pad_copy: assert property (
      wq && qa == `OFF_PAD |=> ##[0:1] periph_addr_flat[0] == pad_e)
      else $error("peripheral address copy wrong");
   a_reset_quiet: assert property (
      $rose(hresetn) |-> chan_busy == 8'h00 && irq == 1'b0)
      else $error("outputs active after reset");
   c_busy: cover property ($rose(chan_busy[0]));
   c_irq: cover property ($rose(irq));
   c_stat: cover property (rq && qa == `OFF_STAT);
endmodule : dma_channels_props
bind dma_channels dma_channels_props #(.NCH(NCH)) i_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .periph_addr_flat(periph_addr_flat), .chan_busy(chan_busy), .irq(irq));

// file: sim/dma_channels_tb.sv
// self-checking bench for the dma channel register block
// assumes: ahb-lite master here, far side model drives events
`timescale 1ns/1ns
`include "dma_consts.svh"
module dma_channels_tb
   import dma_pkg::*;
;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   logic [7:0]  stp;
   logic [7:0]  pcol;
   logic [7:0]  rcol;
   logic [7:0]  busy;
   logic [15:0] ra [8];
   logic [15:0] pa [8];
   int          mismatches = 0;
   int          checked = 0;
   dma_channels i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .xfer_step(stp),
      .periph_collision(pcol), .ram_collision(rcol), .ram_addr_flat(ra),
      .periph_addr_flat(pa), .chan_busy(busy), .irq(irq));
   dma_far_side i_far (.hclk(hclk), .xfer_step(stp),
      .periph_collision(pcol), .ram_collision(rcol));
   // free-running 10 mhz clock
   initial forever #50 hclk = ~hclk;
   task conclude;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // next edge with ready high, bounded
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         mismatches++;
         $display("[ERR] %0t bus wait ran out", $time);
         conclude();
      end
   endtask : wt
   // one single word transfer: address phase, then data phase
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      q = hrdata;
   endtask : xfer
   task rc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rc
   task t_reset;
      for (int i = 0; i < 8; i++)
         for (int k = 0; k < 4; k++)
            rc(12'(i) * `CH_STRIDE + 12'(4 * k), 32'h0);
      rc(`OFF_STAT, 32'h0);
      rc(12'h0fc, 32'h0);
   endtask : t_reset
   // channel 3 is off, so count and address writes are allowed
   task t_regs;
      xfer(1'b1, 12'h060, 32'h0000ffff);
      xfer(1'b1, 12'h064, 32'h0000a5a5);
      xfer(1'b1, 12'h068, 32'h00005a5a);
      xfer(1'b1, 12'h06c, 32'hffffffff);
      rc(12'h060, 32'h0000ffff);
      rc(12'h064, 32'h0000a5a5);
      rc(12'h068, 32'h00005a5a);
      rc(12'h06c, 32'h000003ff);
      chk({16'h0, pa[3]}, 32'h00005a5a);
   endtask : t_regs
   task t_clash;
      i_far.clash(8'h81, 8'h81);
      repeat (2) @(posedge hclk);
      rc(`OFF_STAT, 32'h00008181);
      xfer(1'b1, `OFF_STAT, 32'h00008001);
      rc(`OFF_STAT, 32'h00000180);
      xfer(1'b1, `OFF_STAT, 32'h0000ffff);
      rc(`OFF_STAT, 32'h0);
   endtask : t_clash
   // one-shot block of three items on channel 0
   task t_block;
      xfer(1'b1, `OFF_LENGTH, 32'h2);
      xfer(1'b1, `OFF_PRI_START, 32'h0040);
      xfer(1'b1, `OFF_PAD, 32'h1234);
      xfer(1'b1, `OFF_IRQ_MASK, 32'h1);
      xfer(1'b1, `OFF_CTRL, 32'h8001);
      repeat (3) @(posedge hclk);
      chk({24'h0, busy}, 32'h1);
      chk({16'h0, ra[0]}, 32'h0040);
      chk({16'h0, pa[0]}, 32'h1234);
      i_far.step(0, 2);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      i_far.step(0, 1);
      repeat (3) @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      chk({24'h0, busy}, 32'h0);
      rc(`OFF_IRQ_STAT, 32'h1);
      xfer(1'b1, `OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, `OFF_IRQ_STAT, 32'h1);
      rc(`OFF_IRQ_STAT, 32'h0);
   endtask : t_block
   // continuous ping-pong on channel 1, half-block event, no increment
   task t_pp;
      xfer(1'b1, 12'h02c, 32'h1);
      xfer(1'b1, 12'h020, 32'h0100);
      xfer(1'b1, 12'h024, 32'h0200);
      xfer(1'b1, 12'h030, 32'h9012);
      repeat (3) @(posedge hclk);
      chk({16'h0, ra[1]}, 32'h0100);
      i_far.step(1, 1);
      repeat (3) @(posedge hclk);
      chk({16'h0, ra[1]}, 32'h0100);
      rc(`OFF_IRQ_STAT, 32'h2);
      xfer(1'b1, `OFF_IRQ_STAT, 32'h2);
      i_far.step(1, 1);
      repeat (3) @(posedge hclk);
      chk({16'h0, ra[1]}, 32'h0200);
      rc(`OFF_IRQ_STAT, 32'h0);
      i_far.step(1, 2);
      repeat (3) @(posedge hclk);
      chk({16'h0, ra[1]}, 32'h0100);
   endtask : t_pp
   // reset for two cycles, then the scenarios
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_regs();
      t_clash();
      t_block();
      t_pp();
      conclude();
   end
endmodule : dma_channels_tb
